// file: sim/rbm_bank_mapper_bench.sv
// Self-checking bench of the on-chip RAM bank mapper
`timescale 1ns/1ps
module rbm_bank_mapper_bench;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [7:0] port_two_latch, p2;
	rbm_pkg::rbm_req_t core_req;
	rbm_pkg::rbm_rsp_t core_rsp, rsp;
	rbm_pkg::rbm_ext_t ext_req, ext;
	int bad_count, n_tests;
	rbm_bank_mapper uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_req, .port_two_latch,
		.core_rsp, .ext_req);
	rbm_core_model core (.aclk, .core_req, .port_two_latch, .core_rsp, .ext_req);
	always #50 aclk = ~aclk;
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Every wait is bounded so a silent slave ends the run
	task axi_wr(input logic [11:0] a, input logic [7:0] d);
		int i;
		logic aw_done, w_done;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= 32'(d);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw_done = 1'b0;
		w_done = 1'b0;
		// Each channel is released at the edge that takes it; a slave may take them apart
		for (i = 0; i < 50 && !(aw_done && w_done); i++)
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
			begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1)
			begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		for (i = i; i < 50 && s_axi_bvalid !== 1'b1; i++) @(posedge aclk);
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
		if (i >= 50)
			bad_count++;
		if (i >= 50)
			tally_and_finish;
	endtask
	task axi_rd(input logic [11:0] a);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50 && s_axi_arready !== 1'b1; i++) @(posedge aclk);
		s_axi_arvalid <= 1'b0;
		for (i = i; i < 50 && s_axi_rvalid !== 1'b1; i++) @(posedge aclk);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		if (i >= 50)
			bad_count++;
		if (i >= 50)
			tally_and_finish;
	endtask
	task acc(input rbm_pkg::rbm_mode_t m, input logic we, input logic [15:0] a, input logic [7:0] d);
		core.access(m, we, a, d, p2, rsp, ext);
	endtask
	// Register reset values and an unmapped place
	task t_regs;
		axi_rd(12'h214);
		chk("page", 32'h0, rd);
		chk("rresp", 32'(rbm_pkg::RESP_OKAY), 32'(resp));
		axi_rd(12'h218);
		chk("window", 32'h0, rd);
		axi_rd(12'h2FC);
		chk("system_control_register", 32'h0, rd);
		axi_rd(12'h010);
		chk("rresp", 32'(rbm_pkg::RESP_SLVERR), 32'(resp));
		axi_wr(12'h010, 8'hFF);
		chk("bresp", 32'(rbm_pkg::RESP_SLVERR), 32'(resp));
	endtask
	// Lower 128 bytes: written direct, read back indirect
	task t_lower;
		logic [7:0] a;
		for (int k = 0; k < 4; k++)
		begin
			a = 8'h1F + 8'(k * 16'h20);
			acc(rbm_pkg::MODE_DIRECT, 1'b1, 16'(a), a ^ 8'h5A);
			acc(rbm_pkg::MODE_INDIRECT, 1'b0, 16'(a), 8'h00);
			chk("lower", 32'(a ^ 8'h5A), 32'(rsp.rdata));
		end
	endtask
	// Upper 128 bytes and the bit area
	task t_upper_bits;
		acc(rbm_pkg::MODE_DIRECT, 1'b0, 16'h0090, 8'h00);
		chk("fault", 32'h1, 32'(rsp.fault));
		acc(rbm_pkg::MODE_INDIRECT, 1'b1, 16'h0090, 8'hA7);
		acc(rbm_pkg::MODE_INDIRECT, 1'b0, 16'h0090, 8'h00);
		chk("upper", 32'hA7, 32'(rsp.rdata));
		acc(rbm_pkg::MODE_INDIRECT, 1'b1, 16'h0021, 8'h00);
		acc(rbm_pkg::MODE_BIT, 1'b1, 16'h000B, 8'h01);
		acc(rbm_pkg::MODE_INDIRECT, 1'b0, 16'h0021, 8'h00);
		chk("bitbyte", 32'h08, 32'(rsp.rdata));
		acc(rbm_pkg::MODE_BIT, 1'b0, 16'h0085, 8'h00);
		chk("bitfault", 32'h1, 32'(rsp.fault));
	endtask
	// Expanded RAM off, then on, then beyond its top
	task t_xram;
		acc(rbm_pkg::MODE_XDATA_DATA_POINTER_16, 1'b1, 16'h0123, 8'h11);
		chk("offaddr", 32'h0123, 32'(ext.addr));
		chk("offdata", 32'h111, 32'({ext.we, ext.wdata}));
		axi_wr(12'h2FC, 8'h02);
		chk("bresp", 32'(rbm_pkg::RESP_OKAY), 32'(resp));
		axi_rd(12'h2FC);
		chk("system_control_register", 32'h2, rd);
		acc(rbm_pkg::MODE_XDATA_DATA_POINTER_16, 1'b1, 16'h0123, 8'hA5);
		chk("onchip", 32'h0, 32'(ext.valid));
		acc(rbm_pkg::MODE_XDATA_DATA_POINTER_16, 1'b0, 16'h0123, 8'h00);
		chk("xram", 32'hA5, 32'(rsp.rdata));
		acc(rbm_pkg::MODE_XDATA_DATA_POINTER_16, 1'b0, 16'h0300, 8'h00);
		chk("above", 32'h0300, 32'(ext.addr));
	endtask
	// Every page code of the byte-register moves
	task t_pages;
		for (int k = 0; k < 3; k++)
		begin
			axi_wr(12'h214, 8'(k));
			acc(rbm_pkg::MODE_XDATA_RN, 1'b1, 16'h0010, 8'(8'h30 + k));
			acc(rbm_pkg::MODE_XDATA_DATA_POINTER_16, 1'b0, 16'(k * 256 + 16'h10), 8'h00);
			chk("page", 32'(8'h30 + k), 32'(rsp.rdata));
		end
		axi_wr(12'h214, 8'h03);
		p2 = 8'hC3;
		acc(rbm_pkg::MODE_XDATA_RN, 1'b0, 16'h0021, 8'h00);
		chk("p3addr", 32'h1C321, {15'h0, ext.valid, ext.addr});
		axi_rd(12'h300);
		chk("status", 32'h2, rd);
	endtask
	// Window onto expanded, onto upper core, then switched off
	task t_window;
		axi_wr(12'h218, 8'h8C);
		axi_rd(12'h218);
		chk("window", 32'h8C, rd);
		acc(rbm_pkg::MODE_DIRECT, 1'b1, 16'h0043, 8'h55);
		acc(rbm_pkg::MODE_XDATA_DATA_POINTER_16, 1'b0, 16'h0203, 8'h00);
		chk("winx", 32'h55, 32'(rsp.rdata));
		axi_wr(12'h218, 8'h82);
		acc(rbm_pkg::MODE_DIRECT, 1'b1, 16'h0041, 8'h6E);
		acc(rbm_pkg::MODE_INDIRECT, 1'b0, 16'h0081, 8'h00);
		chk("winc", 32'h6E, 32'(rsp.rdata));
		axi_wr(12'h218, 8'h02);
		acc(rbm_pkg::MODE_DIRECT, 1'b0, 16'h005F, 8'h00);
		chk("winoff", 32'h05, 32'(rsp.rdata));
	endtask
	initial
	begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, p2} = '0;
		s_axi_wstrb = 4'hF;
		bad_count = 0;
		n_tests = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_lower;
		t_upper_bits;
		t_xram;
		t_pages;
		t_window;
		tally_and_finish;
	end
endmodule

// file: sim/rbm_core_model.sv
// Behavioural processor core issuing single data-memory accesses
`timescale 1ns/1ps
module rbm_core_model
(
	input wire logic aclk,
	output rbm_pkg::rbm_req_t core_req,
	output logic [7:0] port_two_latch,
	input wire rbm_pkg::rbm_rsp_t core_rsp,
	input wire rbm_pkg::rbm_ext_t ext_req
);
	initial
	begin
		core_req = '0;
		port_two_latch = 8'h00;
	end
	// Offer for one edge; on release valid drops and we, address and data get inverted so stale values never match
	task access(input rbm_pkg::rbm_mode_t m, input logic we, input logic [15:0] a, input logic [7:0] d,
		input logic [7:0] p2, output rbm_pkg::rbm_rsp_t r, output rbm_pkg::rbm_ext_t x);
		@(posedge aclk);
		core_req <= '{1'b1, m, we, a, d};
		port_two_latch <= p2;
		@(posedge aclk);
		core_req <= '{1'b0, m, ~we, ~a, ~d};
		@(posedge aclk);
		r = core_rsp;
		x = ext_req;
	endtask
endmodule

// file: sim/rbm_monitor.sv
// Checker of core routing and register write handshakes of the bank mapper
`timescale 1ns/1ps
module rbm_monitor
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire rbm_pkg::rbm_req_t core_req,
	input wire rbm_pkg::rbm_rsp_t core_rsp,
	input wire rbm_pkg::rbm_ext_t ext_req
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Each core access answers one cycle later, never without a request
	property p_rsp; core_req.valid |=> core_rsp.valid; endproperty
	a_rsp: assert property (p_rsp) else $error("core answer missing");
	property p_quiet; !core_req.valid |=> !core_rsp.valid && !ext_req.valid; endproperty
	a_quiet: assert property (p_quiet) else $error("answer without request");
	// Direct upper half is refused, lower half stays on chip
	property p_hi; core_req.valid && core_req.mode == rbm_pkg::MODE_DIRECT && core_req.addr[7] |=> core_rsp.fault;
	endproperty
	a_hi: assert property (p_hi) else $error("direct upper byte not refused");
	property p_lo; core_req.valid && core_req.mode == rbm_pkg::MODE_DIRECT && !core_req.addr[7]
		|=> !core_rsp.fault && !ext_req.valid; endproperty
	a_lo: assert property (p_lo) else $error("direct lower byte refused");
	property p_ind; core_req.valid && core_req.mode == rbm_pkg::MODE_INDIRECT |=> !core_rsp.fault; endproperty
	a_ind: assert property (p_ind) else $error("indirect access refused");
	property p_bit; core_req.valid && core_req.mode == rbm_pkg::MODE_BIT && core_req.addr[7] |=> core_rsp.fault;
	endproperty
	a_bit: assert property (p_bit) else $error("bit address out of range taken");
	// Pointer moves beyond the expanded top leave the chip with the same address
	property p_data_pointer_16; core_req.valid && core_req.mode == rbm_pkg::MODE_XDATA_DATA_POINTER_16 && core_req.addr > rbm_pkg::XRAM_TOP
		|=> ext_req.valid && core_rsp.offchip && ext_req.addr == $past(core_req.addr); endproperty
	a_data_pointer_16: assert property (p_data_pointer_16) else $error("pointer move not sent off chip");
	property p_ext; ext_req.valid |-> core_rsp.valid && core_rsp.offchip; endproperty
	a_ext: assert property (p_ext) else $error("external cycle without flag");
	// Register write is taken on both channels together and answered next cycle
	property p_wr; s_axi_awready |-> s_axi_wready ##1 s_axi_bvalid; endproperty
	a_wr: assert property (p_wr) else $error("register write not answered");
endmodule
bind rbm_bank_mapper rbm_monitor mon (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .core_req,
	.core_rsp, .ext_req);

// file: verilog/rbm_bank_mapper.sv
// On-chip 1 KB data RAM with bank mapping, external-data paging and AXI4-Lite registers
//
// Contract
// - 1 KB RAM: 256 core, 768 expanded
// - Expanded RAM disabled after reset
// - 00h-7Fh reachable direct and indirect
// - 00h-1Fh hold working register banks
// - 20h-2Fh also bit addressable
// - 30h-7Fh byte-only general storage
// - 80h-FFh indirect or via window only
// - Expanded RAM at external 0000h-02FFh
// - Pointer access above 02FFh goes off chip
// - 8-bit external moves use page bits
// - Pages 0-2 map to expanded RAM
// - Page 3 drives port-two latch off chip
// - Window enable bit 7 gates 40h-7Fh
// - Low four bits choose window block
// - Codes 0-3 select core RAM blocks
// - Codes 4-15 select expanded RAM blocks
// - Expanded enable is system control bit 1
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module rbm_bank_mapper
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire rbm_pkg::rbm_req_t core_req,
	input wire logic [7:0] port_two_latch,
	output rbm_pkg::rbm_rsp_t core_rsp,
	output rbm_pkg::rbm_ext_t ext_req
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] page_sel;
		logic bank_window_enable;
		logic [3:0] window_sel;
		logic expanded_ram_enable;
		rbm_pkg::rbm_target_t last_target;
		rbm_pkg::rbm_phase_t wph;
		rbm_pkg::rbm_phase_t rph;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		rbm_pkg::rbm_rsp_t rsp;
		rbm_pkg::rbm_ext_t ext;
	} rbm_state_t;

	rbm_state_t s_r;
	rbm_state_t s_nxt;
	logic [7:0] ram [rbm_pkg::RAM_DEPTH];
	logic mem_we;
	logic [9:0] mem_idx;
	logic [7:0] mem_wbyte;

	// Byte address of a register index on the bus
	function automatic logic [11:0] reg_addr(input logic [9:0] idx);
		reg_addr = {idx, 2'b00};
	endfunction

	// Expanded RAM offset to physical index; expanded RAM sits above the core 256
	function automatic logic [9:0] xram_phys(input logic [9:0] xoff);
		xram_phys = rbm_pkg::XRAM_BASE + xoff;
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Core accesses and bus transfers are decoded together in one pass
	always_comb
	begin
		logic onchip, offchip, fault, bitop;
		logic [9:0] phys;
		logic [15:0] xaddr;
		logic [7:0] rd, rbyte;
		onchip = 1'b0;
		offchip = 1'b0;
		fault = 1'b0;
		bitop = 1'b0;
		phys = '0;
		xaddr = '0;
		rd = '0;
		rbyte = '0;
		s_nxt = s_r;
		s_nxt.rsp = '0;
		s_nxt.ext = '0;
		mem_we = 1'b0;
		mem_idx = '0;
		mem_wbyte = '0;

		// Route the core access to core RAM, expanded RAM or the external bus
		case (core_req.mode)
			rbm_pkg::MODE_DIRECT:
			begin
				if (core_req.addr[7:0] > rbm_pkg::DIRECT_TOP)
					fault = 1'b1; // Direct 80h-FFh is special-function space, not RAM
				else if (s_r.bank_window_enable && core_req.addr[7:0] >= rbm_pkg::WIN_LO)
					phys = {s_r.window_sel, core_req.addr[5:0]}; // Blocks line up with the code
				else
					phys = {2'b00, core_req.addr[7:0]};
			end
			rbm_pkg::MODE_INDIRECT:
				phys = {2'b00, core_req.addr[7:0]}; // Whole 256 bytes, windowing never applies
			rbm_pkg::MODE_BIT:
			begin
				// Bit addresses 00h-7Fh land in bytes 20h-2Fh; higher ones belong to registers
				if (core_req.addr[7])
					fault = 1'b1;
				else
				begin
					phys = {2'b00, rbm_pkg::BIT_BASE + {4'h0, core_req.addr[6:3]}};
					bitop = 1'b1;
				end
			end
			rbm_pkg::MODE_XDATA_DATA_POINTER_16:
			begin
				if (s_r.expanded_ram_enable && core_req.addr <= rbm_pkg::XRAM_TOP)
					phys = xram_phys(core_req.addr[9:0]);
				else
				begin
					xaddr = core_req.addr;
					offchip = 1'b1;
				end
			end
			rbm_pkg::MODE_XDATA_RN:
			begin
				if (s_r.page_sel == rbm_pkg::PAGE_OFFCHIP)
				begin
					xaddr = {port_two_latch, core_req.addr[7:0]};
					offchip = 1'b1;
				end
				else if (s_r.expanded_ram_enable)
					phys = xram_phys({s_r.page_sel, core_req.addr[7:0]});
				else
				begin
					xaddr = {6'h00, s_r.page_sel, core_req.addr[7:0]};
					offchip = 1'b1;
				end
			end
			default:
				fault = 1'b1;
		endcase
		onchip = !fault && !offchip; // Every route is exactly one of fault, off chip or on chip

		// Read-modify-write keeps a bit write from disturbing its neighbours
		rd = ram[phys];
		rbyte = rd;
		if (bitop)
		begin
			rbyte = {7'h00, rd[core_req.addr[2:0]]};
			mem_wbyte = rd;
			mem_wbyte[core_req.addr[2:0]] = core_req.wdata[0];
		end
		else
			mem_wbyte = core_req.wdata;
		mem_idx = phys;
		mem_we = core_req.valid && core_req.we && onchip;

		// Answer one cycle after the request and pass off-chip requests on
		if (core_req.valid)
		begin
			s_nxt.rsp.valid = 1'b1;
			s_nxt.rsp.rdata = (onchip && !core_req.we) ? rbyte : 8'h00;
			s_nxt.rsp.offchip = offchip;
			s_nxt.rsp.fault = fault;
			s_nxt.ext.valid = offchip;
			s_nxt.ext.we = core_req.we;
			s_nxt.ext.addr = xaddr;
			s_nxt.ext.wdata = core_req.wdata;
			if (fault)
				s_nxt.last_target = rbm_pkg::TGT_NONE;
			else if (offchip)
				s_nxt.last_target = rbm_pkg::TGT_OFFCHIP;
			else if (phys >= rbm_pkg::XRAM_BASE)
				s_nxt.last_target = rbm_pkg::TGT_XRAM;
			else
				s_nxt.last_target = rbm_pkg::TGT_CORE;
		end

		// Write channel: take address and data together, then answer
		s_nxt.awready = 1'b0;
		s_nxt.wready = 1'b0;
		case (s_r.wph)
			rbm_pkg::PH_IDLE:
			begin
				if (s_axi_awvalid && s_axi_wvalid)
				begin
					s_nxt.awready = 1'b1;
					s_nxt.wready = 1'b1;
					s_nxt.wph = rbm_pkg::PH_ACCEPT;
				end
			end
			rbm_pkg::PH_ACCEPT:
			begin
				s_nxt.bresp = rbm_pkg::RESP_OKAY;
				s_nxt.bvalid = 1'b1;
				s_nxt.wph = rbm_pkg::PH_RESP;
				if (s_axi_awaddr == reg_addr(rbm_pkg::REG_PAGE_IDX))
				begin
					if (s_axi_wstrb[0])
						s_nxt.page_sel = s_axi_wdata[1:0];
				end
				else if (s_axi_awaddr == reg_addr(rbm_pkg::REG_BANK_IDX))
				begin
					if (s_axi_wstrb[0])
					begin
						s_nxt.bank_window_enable = s_axi_wdata[rbm_pkg::BANK_EN_BIT];
						s_nxt.window_sel = s_axi_wdata[3:0];
					end
				end
				else if (s_axi_awaddr == reg_addr(rbm_pkg::REG_SYSTEM_CONTROL_REGISTER_IDX))
				begin
					if (s_axi_wstrb[0])
						s_nxt.expanded_ram_enable = s_axi_wdata[rbm_pkg::XRAM_EN_BIT];
				end
				else if (s_axi_awaddr != reg_addr(rbm_pkg::REG_STATUS_IDX))
					s_nxt.bresp = rbm_pkg::RESP_SLVERR;
			end
			rbm_pkg::PH_RESP:
			begin
				if (s_axi_bready)
				begin
					s_nxt.bvalid = 1'b0;
					s_nxt.wph = rbm_pkg::PH_IDLE;
				end
			end
			default:
				s_nxt.wph = rbm_pkg::PH_IDLE;
		endcase

		// Read channel; unused bits read as zero
		s_nxt.arready = 1'b0;
		case (s_r.rph)
			rbm_pkg::PH_IDLE:
			begin
				if (s_axi_arvalid)
				begin
					s_nxt.arready = 1'b1;
					s_nxt.rph = rbm_pkg::PH_ACCEPT;
				end
			end
			rbm_pkg::PH_ACCEPT:
			begin
				s_nxt.rresp = rbm_pkg::RESP_OKAY;
				s_nxt.rdata = '0;
				s_nxt.rvalid = 1'b1;
				s_nxt.rph = rbm_pkg::PH_RESP;
				if (s_axi_araddr == reg_addr(rbm_pkg::REG_PAGE_IDX))
					s_nxt.rdata[1:0] = s_r.page_sel;
				else if (s_axi_araddr == reg_addr(rbm_pkg::REG_BANK_IDX))
				begin
					s_nxt.rdata[rbm_pkg::BANK_EN_BIT] = s_r.bank_window_enable;
					s_nxt.rdata[3:0] = s_r.window_sel;
				end
				else if (s_axi_araddr == reg_addr(rbm_pkg::REG_SYSTEM_CONTROL_REGISTER_IDX))
					s_nxt.rdata[rbm_pkg::XRAM_EN_BIT] = s_r.expanded_ram_enable;
				else if (s_axi_araddr == reg_addr(rbm_pkg::REG_STATUS_IDX))
					s_nxt.rdata[1:0] = s_r.last_target;
				else
					s_nxt.rresp = rbm_pkg::RESP_SLVERR;
			end
			rbm_pkg::PH_RESP:
			begin
				if (s_axi_rready)
				begin
					s_nxt.rvalid = 1'b0;
					s_nxt.rph = rbm_pkg::PH_IDLE;
				end
			end
			default:
				s_nxt.rph = rbm_pkg::PH_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Reset leaves windowing off, page 0 and expanded RAM disabled
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_r <= '0;
			s_r.page_sel <= rbm_pkg::PAGE_RESET;
			s_r.last_target <= rbm_pkg::TGT_NONE;
		end
		else
			s_r <= s_nxt;
	end

	// RAM contents survive reset, as data memory does
	always_ff @(posedge aclk)
	begin
		if (mem_we)
			ram[mem_idx] <= mem_wbyte;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rresp = s_r.rresp;
	assign s_axi_rdata = s_r.rdata;
	assign core_rsp = s_r.rsp;
	assign ext_req = s_r.ext;
endmodule

// file: verilog/rbm_pkg.sv
// Package: constants, enumerations and carriers for the on-chip RAM bank mapper
package rbm_pkg;
	// ----------------------------------------------------------------
	// Register map (indices; byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [9:0] REG_PAGE_IDX = 10'h085;
	localparam logic [9:0] REG_BANK_IDX = 10'h086;
	localparam logic [9:0] REG_SYSTEM_CONTROL_REGISTER_IDX = 10'h0BF;
	localparam logic [9:0] REG_STATUS_IDX = 10'h0C0;
	localparam int AXI_AW = 12;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int BANK_EN_BIT = 7;
	localparam int XRAM_EN_BIT = 1;
	localparam logic [1:0] PAGE_RESET = 2'h0;
	localparam logic [1:0] PAGE_OFFCHIP = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Data memory geometry
	// ----------------------------------------------------------------
	localparam int RAM_DEPTH = 1024;
	localparam logic [9:0] XRAM_BASE = 10'h100;
	localparam logic [15:0] XRAM_TOP = 16'h02FF;
	localparam logic [7:0] DIRECT_TOP = 8'h7F;
	localparam logic [7:0] REGBANK_TOP = 8'h1F;
	localparam logic [7:0] BIT_BASE = 8'h20;
	localparam logic [7:0] WIN_LO = 8'h40;
	localparam logic [7:0] WIN_HI = 8'h7F;

	// ----------------------------------------------------------------
	// Enumerations and carriers
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {MODE_DIRECT, MODE_INDIRECT, MODE_BIT, MODE_XDATA_DATA_POINTER_16, MODE_XDATA_RN} rbm_mode_t;
	typedef enum logic [1:0] {TGT_CORE, TGT_XRAM, TGT_OFFCHIP, TGT_NONE} rbm_target_t;
	typedef enum logic [1:0] {PH_IDLE, PH_ACCEPT, PH_RESP} rbm_phase_t;

	typedef struct packed {
		logic valid;
		rbm_mode_t mode;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} rbm_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
		logic offchip;
		logic fault;
	} rbm_rsp_t;

	typedef struct packed {
		logic valid;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} rbm_ext_t;
endpackage
